// file: inc/usd_pkg.sv
// Constants and types for the UART shadow data access block
package usd_pkg;
   localparam int ADDR_W = 32;
   localparam int DATA_W = 32;
   localparam int CHAR_W = 8;
   localparam int FIFO_DEPTH = 16;
   localparam int PTR_W = 4;
   localparam int CNT_W = 5;
   localparam int DIV_W = 16;
   localparam int BIT_IDX_W = 3;
   localparam int INT_W = 3;
   localparam logic [CNT_W-1:0] FIFO_FULL_CNT = 5'h10;
   localparam logic [BIT_IDX_W-1:0] LAST_BIT = 3'h7;
   localparam logic [ADDR_W-1:0] SHADOW_BASE = 32'h50001130;
   localparam logic [ADDR_W-1:0] SHADOW_2_ADDR = 32'h50001138;
   localparam logic [ADDR_W-1:0] SHADOW_3_ADDR = 32'h5000113c;
   localparam logic [ADDR_W-1:0] SHADOW_SPAN = 32'h00000040;
   localparam logic [ADDR_W-1:0] FIFO_CONTROL_ADDR = 32'h50001100;
   localparam logic [ADDR_W-1:0] LINE_STATUS_ADDR = 32'h50001104;
   localparam logic [ADDR_W-1:0] MODE_ADDR = 32'h50001108;
   localparam logic [ADDR_W-1:0] DIVISOR_ADDR = 32'h5000110c;
   localparam logic [ADDR_W-1:0] INT_STATUS_ADDR = 32'h50001110;
   localparam logic [ADDR_W-1:0] INT_MASK_ADDR = 32'h50001114;
   localparam int FCTL_EN_BIT = 0;
   localparam int MODE_IR_BIT = 0;
   localparam int LS_READY_BIT = 0;
   localparam int LS_OE_BIT = 1;
   localparam int LS_TX_EMPTY_BIT = 5;
   localparam int INT_RX_BIT = 0;
   localparam int INT_OE_BIT = 1;
   localparam int INT_TXE_BIT = 2;
   localparam logic [DIV_W-1:0] DIV_RESET = 16'h0364;
   localparam logic [DIV_W-1:0] DIV_MIN = 16'h0004;
   localparam logic [DATA_W-1:0] ZERO_WORD = 32'h00000000;
   typedef enum logic [3:0] {
      SER_IDLE = 4'b0001,
      SER_START = 4'b0010,
      SER_DATA = 4'b0100,
      SER_STOP = 4'b1000
   } usd_ser_t;
endpackage : usd_pkg

// file: rtl/usd_fifo.sv
// Character FIFO, instanced once for the receive path and once for the transmit path
`timescale 1ns/1ps
module usd_fifo
   import usd_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic flush,
   input wire logic push,
   input wire logic pop,
   input wire logic [CHAR_W-1:0] wdata,
   output logic [CHAR_W-1:0] rdata,
   output logic full,
   output logic empty,
   output logic [CNT_W-1:0] count
);
   logic [CHAR_W-1:0] mem [FIFO_DEPTH];
   logic [PTR_W-1:0] wptr_reg;
   logic [PTR_W-1:0] rptr_reg;
   logic [CNT_W-1:0] cnt_reg;
   wire do_pop = pop && !empty;
   // Push into a full FIFO only when a pop frees a slot in the same cycle
   wire do_push = push && (!full || do_pop);

   assign full = cnt_reg == FIFO_FULL_CNT;
   assign empty = cnt_reg == '0;
   assign count = cnt_reg;
   assign rdata = mem[rptr_reg];

   always_ff @(posedge pclk) begin
      if (do_push) begin
         mem[wptr_reg] <= wdata;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wptr_reg <= '0;
         rptr_reg <= '0;
         cnt_reg <= '0;
      end else if (flush) begin
         wptr_reg <= '0;
         rptr_reg <= '0;
         cnt_reg <= '0;
      end else begin
         wptr_reg <= wptr_reg + PTR_W'(do_push);
         rptr_reg <= rptr_reg + PTR_W'(do_pop);
         cnt_reg <= cnt_reg + CNT_W'(do_push) - CNT_W'(do_pop);
      end
   end
endmodule : usd_fifo

// file: rtl/usd_serial.sv
// 8N1 serial shifter pair with infrared pulse mode
`timescale 1ns/1ps
module usd_serial
   import usd_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [DIV_W-1:0] divisor,
   input wire logic ir_mode,
   input wire logic tx_valid,
   input wire logic [CHAR_W-1:0] tx_data,
   output logic tx_take,
   output logic rx_valid,
   output logic [CHAR_W-1:0] rx_data,
   input wire logic sin,
   input wire logic sir_in,
   output logic sout,
   output logic sir_out_n
);
   usd_ser_t tx_st_reg;
   usd_ser_t rx_st_reg;
   logic [DIV_W-1:0] tx_cnt_reg;
   logic [DIV_W-1:0] rx_cnt_reg;
   logic [DIV_W-1:0] ir_cnt_reg;
   logic [BIT_IDX_W-1:0] tx_bit_reg;
   logic [BIT_IDX_W-1:0] rx_bit_reg;
   logic [CHAR_W-1:0] tx_sh_reg;
   logic [CHAR_W-1:0] rx_sh_reg;
   logic tx_level;
   wire [DIV_W-1:0] period = (divisor < DIV_MIN) ? DIV_MIN : divisor;
   wire [DIV_W-1:0] reload = period - DIV_W'(1);
   wire tx_end = tx_cnt_reg == '0;
   wire rx_end = rx_cnt_reg == '0;
   // Infrared pulse occupies the first quarter of a zero bit
   wire ir_pulse = tx_cnt_reg >= (period - (period >> 2));
   // A short infrared pulse is stretched to a bit so mid-bit sampling sees it
   wire rx_line = ir_mode ? !(sir_in || ir_cnt_reg != '0) : sin;

   assign tx_take = (tx_st_reg == SER_IDLE) && tx_valid;

   always_comb begin
      case (tx_st_reg)
         SER_START: tx_level = 1'b0;
         SER_DATA: tx_level = tx_sh_reg[0];
         default: tx_level = 1'b1;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sout <= 1'b1;
         sir_out_n <= 1'b1;
      end else begin
         sout <= ir_mode || tx_level;
         sir_out_n <= !(ir_mode && !tx_level && ir_pulse);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_st_reg <= SER_IDLE;
         tx_cnt_reg <= '0;
         tx_bit_reg <= '0;
         tx_sh_reg <= '0;
      end else begin
         tx_cnt_reg <= tx_end ? reload : tx_cnt_reg - DIV_W'(1);
         case (tx_st_reg)
            SER_IDLE: if (tx_valid) begin
               tx_st_reg <= SER_START;
               tx_sh_reg <= tx_data;
               tx_cnt_reg <= reload;
            end
            SER_START: if (tx_end) begin
               tx_st_reg <= SER_DATA;
               tx_bit_reg <= '0;
            end
            SER_DATA: if (tx_end) begin
               tx_sh_reg <= tx_sh_reg >> 1;
               tx_bit_reg <= tx_bit_reg + BIT_IDX_W'(1);
               if (tx_bit_reg == LAST_BIT) begin
                  tx_st_reg <= SER_STOP;
               end
            end
            SER_STOP: if (tx_end) begin
               tx_st_reg <= SER_IDLE;
            end
            default: tx_st_reg <= SER_IDLE;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ir_cnt_reg <= '0;
      end else if (sir_in) begin
         ir_cnt_reg <= reload;
      end else if (ir_cnt_reg != '0) begin
         ir_cnt_reg <= ir_cnt_reg - DIV_W'(1);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_st_reg <= SER_IDLE;
         rx_cnt_reg <= '0;
         rx_bit_reg <= '0;
         rx_sh_reg <= '0;
         rx_data <= '0;
         rx_valid <= 1'b0;
      end else begin
         rx_valid <= 1'b0;
         rx_cnt_reg <= rx_end ? reload : rx_cnt_reg - DIV_W'(1);
         case (rx_st_reg)
            SER_IDLE: if (!rx_line) begin
               rx_st_reg <= SER_START;
               rx_cnt_reg <= period >> 1;
            end
            SER_START: if (rx_end) begin
               rx_st_reg <= rx_line ? SER_IDLE : SER_DATA;
               rx_bit_reg <= '0;
            end
            SER_DATA: if (rx_end) begin
               rx_sh_reg <= {rx_line, rx_sh_reg[CHAR_W-1:1]};
               rx_bit_reg <= rx_bit_reg + BIT_IDX_W'(1);
               if (rx_bit_reg == LAST_BIT) begin
                  rx_st_reg <= SER_STOP;
               end
            end
            SER_STOP: if (rx_end) begin
               // Framing errors drop the character
               rx_st_reg <= SER_IDLE;
               rx_valid <= rx_line;
               rx_data <= rx_sh_reg;
            end
            default: rx_st_reg <= SER_IDLE;
         endcase
      end
   end
endmodule : usd_serial

// file: rtl/usd_uart_shadow.sv
// APB slave for UART shadow data access with receive and transmit paths
`timescale 1ns/1ps
module usd_uart_shadow
   import usd_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [DATA_W-1:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic sin,
   input wire logic sir_in,
   output logic sout,
   output logic sir_out_n,
   output logic irq
);
   function automatic logic addr_is(input logic [ADDR_W-1:0] a,
                                    input logic [ADDR_W-1:0] b);
      addr_is = a == b;
   endfunction : addr_is

   logic fifo_en_reg;
   logic ir_mode_reg;
   logic [DIV_W-1:0] divisor_reg;
   logic overrun_reg;
   logic [INT_W-1:0] int_status_reg;
   logic [INT_W-1:0] int_mask_reg;
   logic [DATA_W-1:0] prdata_reg;
   logic rd_valid_reg;
   logic slverr_reg;
   logic tx_empty_dly_reg;

   logic [CHAR_W-1:0] rx_head;
   logic rx_fifo_full;
   logic rx_fifo_empty;
   logic [CHAR_W-1:0] tx_head;
   logic tx_fifo_full;
   logic tx_fifo_empty;
   logic tx_take;
   logic rx_valid;
   logic [CHAR_W-1:0] rx_char;

   // Address decode
   wire shadow_hit = (paddr >= SHADOW_BASE) &&
                     (paddr < SHADOW_BASE + SHADOW_SPAN) &&
                     (paddr[1:0] == 2'b00);
   wire fctl_hit = addr_is(paddr, FIFO_CONTROL_ADDR);
   wire lstat_hit = addr_is(paddr, LINE_STATUS_ADDR);
   wire mode_hit = addr_is(paddr, MODE_ADDR);
   wire div_hit = addr_is(paddr, DIVISOR_ADDR);
   wire istat_hit = addr_is(paddr, INT_STATUS_ADDR);
   wire imask_hit = addr_is(paddr, INT_MASK_ADDR);
   wire mapped = shadow_hit || fctl_hit || lstat_hit || mode_hit ||
                 div_hit || istat_hit || imask_hit;

   // No wait states: setup cycle loads read data, access cycle completes
   wire setup = psel && !penable;
   wire access = psel && penable;
   wire wr_lo = access && pwrite && pstrb[0] && !slverr_reg;
   wire wr_hi = access && pwrite && pstrb[1] && !slverr_reg;
   wire rd_acc = access && !pwrite && !slverr_reg;

   // Non-FIFO mode behaves as a one-entry buffer
   wire rx_full = fifo_en_reg ? rx_fifo_full : !rx_fifo_empty;
   wire tx_full = fifo_en_reg ? tx_fifo_full : !tx_fifo_empty;
   wire rx_overrun = rx_valid && rx_full;
   wire rx_overwrite = rx_overrun && !fifo_en_reg;
   wire rx_push = rx_valid && (!rx_full || !fifo_en_reg);
   // A read pops only what was at the head when its data was captured
   wire rx_pop = (rd_acc && shadow_hit && rd_valid_reg) ||
                 rx_overwrite;
   wire tx_wr = wr_lo && shadow_hit;
   wire tx_overwrite = tx_wr && !fifo_en_reg && !tx_fifo_empty &&
                       !tx_take;
   // Non-FIFO holding slot freed by the shifter this cycle still takes the write
   wire tx_push = tx_wr && (!tx_full || tx_overwrite ||
                            (tx_take && !fifo_en_reg));
   wire tx_pop = tx_take || tx_overwrite;
   wire tx_holding_empty = tx_fifo_empty;
   wire rx_data_ready = !rx_fifo_empty;
   wire fifo_toggle = wr_lo && fctl_hit &&
                      (pwdata[FCTL_EN_BIT] != fifo_en_reg);

   wire [DATA_W-1:0] line_status_word =
      ZERO_WORD | (DATA_W'(rx_data_ready) << LS_READY_BIT) |
      (DATA_W'(overrun_reg) << LS_OE_BIT) |
      (DATA_W'(tx_holding_empty) << LS_TX_EMPTY_BIT);
   wire [INT_W-1:0] int_events = (INT_W'(rx_push) << INT_RX_BIT) |
      (INT_W'(rx_overrun) << INT_OE_BIT) |
      (INT_W'(tx_holding_empty && !tx_empty_dly_reg) << INT_TXE_BIT);
   wire [INT_W-1:0] int_clear = (wr_lo && istat_hit) ?
                                pwdata[INT_W-1:0] : '0;

   logic [DATA_W-1:0] rd_word;
   always_comb begin
      rd_word = ZERO_WORD;
      if (shadow_hit) begin
         rd_word = {{(DATA_W-CHAR_W){1'b0}}, rx_head};
      end else if (fctl_hit) begin
         rd_word = DATA_W'(fifo_en_reg) << FCTL_EN_BIT;
      end else if (lstat_hit) begin
         rd_word = line_status_word;
      end else if (mode_hit) begin
         rd_word = DATA_W'(ir_mode_reg) << MODE_IR_BIT;
      end else if (div_hit) begin
         rd_word = DATA_W'(divisor_reg);
      end else if (istat_hit) begin
         rd_word = DATA_W'(int_status_reg);
      end else if (imask_hit) begin
         rd_word = DATA_W'(int_mask_reg);
      end
   end

   assign pready = penable;
   assign pslverr = penable && slverr_reg;
   assign prdata = prdata_reg;
   assign irq = |(int_status_reg & int_mask_reg);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_reg <= ZERO_WORD;
         rd_valid_reg <= 1'b0;
         slverr_reg <= 1'b0;
      end else if (setup) begin
         prdata_reg <= pwrite ? ZERO_WORD : rd_word;
         // An overwrite at this edge leaves the new char for the next read
         rd_valid_reg <= rx_data_ready && !rx_overwrite;
         slverr_reg <= !mapped;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fifo_en_reg <= 1'b0;
         ir_mode_reg <= 1'b0;
         divisor_reg <= DIV_RESET;
         int_mask_reg <= '0;
      end else begin
         if (wr_lo && fctl_hit) begin
            fifo_en_reg <= pwdata[FCTL_EN_BIT];
         end
         if (wr_lo && mode_hit) begin
            ir_mode_reg <= pwdata[MODE_IR_BIT];
         end
         if (div_hit) begin
            divisor_reg[CHAR_W-1:0] <= wr_lo ? pwdata[CHAR_W-1:0] :
                                       divisor_reg[CHAR_W-1:0];
            divisor_reg[DIV_W-1:CHAR_W] <= wr_hi ?
               pwdata[DIV_W-1:CHAR_W] : divisor_reg[DIV_W-1:CHAR_W];
         end
         if (wr_lo && imask_hit) begin
            int_mask_reg <= pwdata[INT_W-1:0];
         end
      end
   end

   // Flags set by hardware win over a clear in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         overrun_reg <= 1'b0;
         int_status_reg <= '0;
         tx_empty_dly_reg <= 1'b1;
      end else begin
         overrun_reg <= rx_overrun ||
                        (overrun_reg && !(rd_acc && lstat_hit));
         int_status_reg <= int_events | (int_status_reg & ~int_clear);
         tx_empty_dly_reg <= tx_holding_empty;
      end
   end

   usd_fifo u_rx_fifo (
      .pclk(pclk),
      .presetn(presetn),
      .flush(fifo_toggle),
      .push(rx_push),
      .pop(rx_pop),
      .wdata(rx_char),
      .rdata(rx_head),
      .full(rx_fifo_full),
      .empty(rx_fifo_empty),
      .count()
   );

   usd_fifo u_tx_fifo (
      .pclk(pclk),
      .presetn(presetn),
      .flush(fifo_toggle),
      .push(tx_push),
      .pop(tx_pop),
      .wdata(pwdata[CHAR_W-1:0]),
      .rdata(tx_head),
      .full(tx_fifo_full),
      .empty(tx_fifo_empty),
      .count()
   );

   usd_serial u_serial (
      .pclk(pclk),
      .presetn(presetn),
      .divisor(divisor_reg),
      .ir_mode(ir_mode_reg),
      .tx_valid(!tx_fifo_empty),
      .tx_data(tx_head),
      .tx_take(tx_take),
      .rx_valid(rx_valid),
      .rx_data(rx_char),
      .sin(sin),
      .sir_in(sir_in),
      .sout(sout),
      .sir_out_n(sir_out_n)
   );
endmodule : usd_uart_shadow

// file: testbench/tb_top.sv
// Self-checking bench for the UART shadow data block
`timescale 1ns/1ps
module tb_top
   import usd_pkg::*;
;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [ADDR_W-1:0] paddr;
   logic [DATA_W-1:0] pwdata, prdata;
   logic sin, sir_in, sout, sir_out_n, irq;
   int err_count, total_checks;
   logic [7:0] rx_m[$], tx_m[$];
   usd_uart_shadow usd_uart_shadow_inst (.pclk(pclk), .presetn(presetn),
      .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
      .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .sin(sin), .sir_in(sir_in), .sout(sout),
      .sir_out_n(sir_out_n), .irq(irq));
   usd_serial_peer #(.BIT_CYC(8)) usd_serial_peer_inst (.pclk(pclk),
      .sout(sout), .sir_out_n(sir_out_n), .sin(sin), .sir_in(sir_in));
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic results;
      $display("checks %0d errors %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : results
   task automatic apb(input logic w, input logic [31:0] a,
      input logic [31:0] d, output logic [31:0] r, output logic e);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      // Waits as long as the slave stalls; only the watchdog ends a hang
      while (pready !== 1'b1) begin
         @(posedge pclk);
      end
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
   endtask : wr
   task automatic rd(input logic [31:0] a, output logic [31:0] r);
      logic e;
      apb(1'b0, a, 32'h0, r, e);
   endtask : rd
   // Waits for n chars at the peer, then compares them in order
   task automatic tx_drain(input int n);
      int k;
      k = 0;
      while (usd_serial_peer_inst.rx_q.size() < n && k < 4000) begin
         k++;
         @(posedge pclk);
      end
      chk(usd_serial_peer_inst.rx_q.size(), n);
      while (usd_serial_peer_inst.rx_q.size() > 0 && tx_m.size() > 0) begin
         chk(usd_serial_peer_inst.rx_q.pop_front(),
             tx_m.pop_front());
      end
   endtask : tx_drain
   initial begin
      repeat (20000) @(posedge pclk);
      err_count++;
      results();
   end
   initial begin
      logic [31:0] r, d;
      logic e;
      logic [7:0] c;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      void'($urandom(93));
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      rd(LINE_STATUS_ADDR, r);
      chk(r, 32'h20);
      wr(DIVISOR_ADDR, 32'h8);
      apb(1'b0, 32'h50001180, 32'h0, r, e);
      chk({r[31:1], e}, 32'h1);
      // Two chars with no read between: second overwrites the first
      for (int i = 0; i < 2; i++) begin
         c = 8'($urandom);
         usd_serial_peer_inst.send(c);
      end
      repeat (4) @(posedge pclk);
      rd(LINE_STATUS_ADDR, r);
      chk(r, 32'h23);
      rd(SHADOW_2_ADDR, r);
      chk(r, {24'h0, c});
      rd(LINE_STATUS_ADDR, r);
      chk(r, 32'h20);
      // Holding register overwritten while the shifter is busy
      for (int i = 0; i < 3; i++) begin
         d = $urandom;
         if (i != 1) tx_m.push_back(d[7:0]);
         wr(SHADOW_3_ADDR, d);
      end
      rd(LINE_STATUS_ADDR, r);
      chk(r, 32'h00);
      tx_drain(2);
      wr(FIFO_CONTROL_ADDR, 32'h1);
      // Seventeen chars into sixteen entries: the last one is lost
      for (int i = 0; i < 17; i++) begin
         c = 8'($urandom);
         if (i < 16) rx_m.push_back(c);
         usd_serial_peer_inst.send(c);
      end
      repeat (4) @(posedge pclk);
      rd(LINE_STATUS_ADDR, r);
      chk(r, 32'h23);
      for (int i = 0; i < 16; i++) begin
         rd(SHADOW_BASE + 32'(4 * i), r);
         chk(r, {24'h0, rx_m.pop_front()});
      end
      rd(LINE_STATUS_ADDR, r);
      chk(r, 32'h20);
      // Shifter takes one, sixteen queue, the rest are discarded
      for (int i = 0; i < 19; i++) begin
         d = $urandom;
         if (i < 17) tx_m.push_back(d[7:0]);
         wr(SHADOW_BASE + 32'(4 * (i % 16)), d);
      end
      rd(LINE_STATUS_ADDR, r);
      chk(r, 32'h00);
      tx_drain(17);
      rd(LINE_STATUS_ADDR, r);
      chk(r, 32'h20);
      // Receive interrupt: masked, unmasked, then cleared
      wr(INT_STATUS_ADDR, 32'h7);
      c = 8'($urandom);
      usd_serial_peer_inst.send(c);
      repeat (4) @(posedge pclk);
      chk(irq, 1'b0);
      rd(INT_STATUS_ADDR, r);
      chk(r[0], 1'b1);
      wr(INT_MASK_ADDR, 32'h1);
      @(posedge pclk);
      chk(irq, 1'b1);
      wr(INT_STATUS_ADDR, 32'h1);
      @(posedge pclk);
      chk(irq, 1'b0);
      rd(SHADOW_BASE, r);
      chk(r, {24'h0, c});
      // Infrared mode: pulses on both infrared pins, sout stays idle
      wr(MODE_ADDR, 32'h1);
      c = 8'($urandom);
      usd_serial_peer_inst.send_ir(c);
      repeat (4) @(posedge pclk);
      rd(SHADOW_BASE, r);
      chk(r, {24'h0, c});
      d = $urandom;
      tx_m.push_back(d[7:0]);
      wr(SHADOW_2_ADDR, d);
      tx_drain(1);
      results();
   end
endmodule : tb_top
bind usd_uart_shadow usd_uart_shadow_chk #(.BIT_CYC(8))
   usd_uart_shadow_chk_inst (
   .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
   .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .sout(sout), .sir_out_n(sir_out_n), .irq(irq));

// file: testbench/usd_serial_peer.sv
// Remote 8N1 transceiver model on the serial pins
`timescale 1ns/1ps
module usd_serial_peer #(
   parameter int BIT_CYC = 8
)
(
   input wire logic pclk,
   input wire logic sout,
   input wire logic sir_out_n,
   output logic sin,
   output logic sir_in
);
   logic [7:0] rx_q[$];
   initial sin = 1'b1;
   initial sir_in = 1'b0;
   // Start, eight data bits LSB first, stop; line idles high
   task automatic send(input logic [7:0] c);
      logic [9:0] f;
      f = {1'b1, c, 1'b0};
      for (int i = 0; i < 10; i++) begin
         sin <= f[i];
         repeat (BIT_CYC) @(posedge pclk);
      end
   endtask : send
   // Infrared: a zero bit is a high pulse over its first quarter
   task automatic send_ir(input logic [7:0] c);
      logic [9:0] f;
      f = {1'b1, c, 1'b0};
      for (int i = 0; i < 10; i++) begin
         sir_in <= !f[i];
         repeat (BIT_CYC / 4) @(posedge pclk);
         sir_in <= 1'b0;
         repeat (BIT_CYC - BIT_CYC / 4) @(posedge pclk);
      end
   endtask : send_ir
   // Mid-bit sampling; a bad stop bit drops the char
   always begin
      logic [7:0] c;
      @(negedge sout);
      repeat (BIT_CYC / 2) @(posedge pclk);
      for (int i = 0; i < 8; i++) begin
         repeat (BIT_CYC) @(posedge pclk);
         c[i] = sout;
      end
      repeat (BIT_CYC) @(posedge pclk);
      if (sout === 1'b1) begin
         rx_q.push_back(c);
      end
   end
   // Infrared receive: sample one cycle into each bit, inside any pulse
   always begin
      logic [7:0] c;
      @(negedge sir_out_n);
      @(posedge pclk);
      for (int i = 0; i < 8; i++) begin
         repeat (BIT_CYC) @(posedge pclk);
         c[i] = sir_out_n;
      end
      rx_q.push_back(c);
   end
endmodule : usd_serial_peer

// file: testbench/usd_uart_shadow_chk.sv
// Port-level checker for the UART shadow data block
`timescale 1ns/1ps
module usd_uart_shadow_chk
   import usd_pkg::*;
#(
   parameter int BIT_CYC = 8
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [DATA_W-1:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic sout,
   input wire logic sir_out_n,
   input wire logic irq
);
   wire shadow_hit;
   assign shadow_hit = (paddr >= SHADOW_BASE) &&
      (paddr < SHADOW_BASE + SHADOW_SPAN) && (paddr[1:0] == 2'h0);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   sequence apb_access;
      psel && penable;
   endsequence
   sequence shadow_read;
      psel && penable && !pwrite && shadow_hit;
   endsequence
   // Bits are held for the programmed divisor, or 4 cycles if it is below 4; bench runs divisor 8
   access_ready_a: assert property (apb_access |-> pready)
      else $error("pready low in access");
   setup_noerr_a: assert property (psel && !penable |-> !pslverr)
      else $error("pslverr outside access");
   shadow_ok_a: assert property (shadow_read |-> !pslverr)
      else $error("shadow read refused");
   upper_zero_a: assert property
      (shadow_read |-> prdata[31:8] == 24'h0)
      else $error("shadow upper bits not zero");
   unmapped_zero_a: assert property (apb_access ##0 (pslverr && !pwrite)
      |-> prdata == ZERO_WORD)
      else $error("refused read returned data");
   bit_low_a: assert property ($fell(sout) |-> !sout [*8])
      else $error("low bit shorter than a bit time");
   bit_high_a: assert property ($rose(sout) |-> sout [*8])
      else $error("high bit shorter than a bit time");
   out_excl_a: assert property (!sout |-> sir_out_n)
      else $error("both transmit outputs active");
   irq_reset_a: assert property ($rose(presetn) |-> !irq)
      else $error("irq high after reset");
endmodule : usd_uart_shadow_chk
